// [inc/pmc_pkg.sv]
// package of constants and types for the power mode controller
// ==========================================================================
package pmc_pkg;
   // ========================================================================
   // clock and timing
   localparam int unsigned CLK_HZ         = 20_000_000;
   localparam int unsigned CPU_HZ         = 80_000_000;
   localparam int unsigned PLL_MULT       = CPU_HZ / CLK_HZ;
   localparam int unsigned DS_WAKE_US     = 3000;
   localparam int unsigned HIB_WAKE_US    = 15000;
   localparam int unsigned SHUT_WAKE_MS   = 1100;
   localparam int unsigned LONG_SLEEP_S   = 22;
   // longest times round down; the deep sleep bound is strict so take one less
   localparam int unsigned DS_WAKE_CYC    = DS_WAKE_US * (CLK_HZ / 1_000_000) - 1;
   localparam int unsigned HIB_WAKE_CYC   = HIB_WAKE_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SHUT_WAKE_CYC  = SHUT_WAKE_MS * (CLK_HZ / 1000);
   localparam longint unsigned LONG_SLEEP_CYC = longint'(LONG_SLEEP_S) * CLK_HZ;
   // ========================================================================
   // apb register map (byte offsets)
   localparam logic [7:0] REG_MODE_REQ   = 8'h00;
   localparam logic [7:0] REG_MODE_STAT  = 8'h04;
   localparam logic [7:0] REG_WAKE_CFG   = 8'h08;
   localparam logic [7:0] REG_RETAIN     = 8'h0C;
   localparam logic [7:0] REG_FTIMER     = 8'h10;
   localparam logic [7:0] REG_NET_CFG    = 8'h14;
   localparam logic [7:0] REG_IRQ_STAT   = 8'h18;
   localparam logic [7:0] REG_IRQ_MASK   = 8'h1C;
   localparam logic [7:0] REG_CFG_KEEP   = 8'h20;
   // wake configuration bit positions
   localparam int unsigned WK_FTIMER     = 0;
   localparam int unsigned WK_GPIO       = 1;
   localparam int unsigned WK_PERIPH     = 2;
   localparam int unsigned WK_RTC        = 3;
   localparam int unsigned WK_GPIO_SEL   = 8;
   // interrupt status bit positions
   localparam int unsigned IRQ_WAKE      = 0;
   localparam int unsigned IRQ_REJECT    = 1;
   localparam int unsigned IRQ_NET_WAKE  = 2;
   localparam int unsigned IRQ_W         = 3;
   localparam logic [31:0] RESET_WORD    = 32'h0000_0000;
   // ========================================================================
   // modes, ordered by falling power from active to shutdown; waking comes last
   typedef enum logic [2:0]
   {
      PMC_ACTIVE    = 3'b000,
      PMC_SLEEP     = 3'b001,
      PMC_DEEP      = 3'b010,
      PMC_HIBERNATE = 3'b011,
      PMC_SHUTDOWN  = 3'b100,
      PMC_WAKING    = 3'b101
   } pmc_mode_t;
   typedef enum logic [1:0]
   {
      PMC_NET_ACTIVE = 2'b00,
      PMC_NET_LISTEN = 2'b01,
      PMC_NET_DEEP   = 2'b10,
      PMC_NET_OFF    = 2'b11
   } pmc_net_t;
endpackage

// [rtl/pmc_sync.sv]
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pmc_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // data
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta;
   // first flop feeds only the second
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta <= '0;
         dout <= '0;
      end
      else
      begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule // pmc_sync

// [rtl/pmc_top.sv]
// power mode controller: processor mode machine, network cycle, apb slave
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module pmc_top
   import pmc_pkg::*;
#(
   parameter int unsigned      GPIO_W        = 8,
   parameter int unsigned      BANKS         = 4,
   parameter int unsigned      DS_WAKE       = pmc_pkg::DS_WAKE_CYC,
   parameter int unsigned      HIB_WAKE      = pmc_pkg::HIB_WAKE_CYC,
   parameter int unsigned      SHUT_WAKE     = pmc_pkg::SHUT_WAKE_CYC,
   parameter longint unsigned  LONG_SLEEP    = pmc_pkg::LONG_SLEEP_CYC,
   parameter int unsigned      BEACON_PERIOD = 2048,
   parameter int unsigned      LISTEN_WIN    = 64
) (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // external pins
   input  wire logic              shutdown_control_line_n,
   input  wire logic [GPIO_W-1:0] gpio_in,
   input  wire logic              periph_activity,
   input  wire logic              rtc_expired,
   // network receive side
   input  wire logic              net_traffic,
   input  wire logic              frame_valid,
   input  wire logic              frame_is_beacon,
   input  wire logic              beacon_pending,
   // power and clock controls
   output logic                   cpu_clk_en,
   output logic [2:0]             cpu_clk_mult,
   output logic                   cpu_state_keep,
   output logic                   cfg_keep_en,
   output logic [BANKS-1:0]       mem_bank_on,
   output logic                   logic_power_on,
   output logic                   rtc_power_on,
   output logic                   app_reload,
   output logic                   net_state_keep,
   output logic                   frame_accept,
   output logic                   irq
);
   import pmc_pkg::*;

   // ========================================================================
   // elaboration checks
   if (GPIO_W < 1 || GPIO_W > 8) $error("GPIO_W must be 1 to 8");
   if (BANKS < 1 || BANKS > 8) $error("BANKS must be 1 to 8");
   if (DS_WAKE < 1 || HIB_WAKE < 1 || SHUT_WAKE < 1) $error("wake counts below one");
   if (BEACON_PERIOD <= LISTEN_WIN) $error("listen window exceeds beacon period");

   // ========================================================================
   // pin synchronisers
   logic [GPIO_W+2:0] sync_out;
   logic [GPIO_W-1:0] gpio_s;
   logic              periph_s;
   logic              rtc_s;
   logic              shut_n_s;
   pmc_sync #(.W(GPIO_W + 3)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     ({~shutdown_control_line_n, rtc_expired, periph_activity, gpio_in}),
      .dout    (sync_out)
   );
   // shutdown line travels inverted: the flops clear to zero, and a plain copy
   // would fake a shutdown for two cycles after every reset
   assign gpio_s   = sync_out[GPIO_W-1:0];
   assign periph_s = sync_out[GPIO_W];
   assign rtc_s    = sync_out[GPIO_W+1];
   assign shut_n_s = ~sync_out[GPIO_W+2];

   // ========================================================================
   // register state
   pmc_mode_t         mode;
   pmc_mode_t         target;
   pmc_net_t          net;
   logic [3:0]        wake_cfg;
   logic [GPIO_W-1:0] gpio_sel;
   logic [BANKS-1:0]  retain;
   logic [15:0]       ftimer_load;
   logic [15:0]       ftimer;
   logic              long_en;
   logic              net_en;
   logic [IRQ_W-1:0]  irq_stat;
   logic [IRQ_W-1:0]  irq_mask;
   logic [31:0]       cfg_keep;
   logic [31:0]       wake_cnt;
   logic [34:0]       net_cnt;
   logic [GPIO_W-1:0] gpio_d;
   logic              wake_pend;
   logic              wr_req;
   logic              rd_req;

   assign wr_req = psel && penable && pwrite;
   assign rd_req = psel && penable && !pwrite;

   // ========================================================================
   // wake sources per mode
   logic gpio_evt;
   logic wake_hit;
   logic mode_wr;
   logic req_ok;
   assign gpio_evt = |(gpio_s & ~gpio_d);
   always_comb
   begin
      wake_hit = 1'b0;
      case (mode)
         PMC_SLEEP:
            wake_hit = (wake_cfg[WK_FTIMER] && ftimer == 16'h0001)
                     || (wake_cfg[WK_GPIO] && gpio_evt)
                     || (wake_cfg[WK_PERIPH] && periph_s);
         PMC_DEEP, PMC_HIBERNATE:
            wake_hit = (wake_cfg[WK_RTC] && rtc_s)
                     || (wake_cfg[WK_GPIO] && |(gpio_s & ~gpio_d & gpio_sel));
         default: wake_hit = 1'b0;
      endcase
   end
   // a request while a wake is pending is dropped
   assign mode_wr = wr_req && paddr == REG_MODE_REQ;
   assign req_ok  = mode_wr && !wake_pend && !wake_hit && mode == PMC_ACTIVE
                  && pwdata[2:0] <= PMC_HIBERNATE && pwdata[2:0] != PMC_ACTIVE;

   // ========================================================================
   // processor mode machine, changed only by software, wake or the shutdown line
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode     <= PMC_ACTIVE;
         target   <= PMC_ACTIVE;
         wake_cnt <= '0;
      end
      else if (!shut_n_s)
      begin
         mode     <= PMC_SHUTDOWN;
         wake_cnt <= '0;
      end
      else
      begin
         case (mode)
            PMC_ACTIVE:
               if (req_ok)
               begin
                  mode   <= pmc_mode_t'(pwdata[2:0]);
                  target <= pmc_mode_t'(pwdata[2:0]);
               end
            PMC_SLEEP:
               if (wake_hit)
                  mode <= PMC_ACTIVE;
            PMC_DEEP, PMC_HIBERNATE:
               if (wake_hit)
               begin
                  mode     <= PMC_WAKING;
                  target   <= mode;
                  wake_cnt <= (mode == PMC_DEEP) ? DS_WAKE - 1 : HIB_WAKE - 1;
               end
            PMC_SHUTDOWN:
            begin
               mode     <= PMC_WAKING;
               target   <= PMC_SHUTDOWN;
               wake_cnt <= SHUT_WAKE - 1;
            end
            PMC_WAKING:
               if (wake_cnt == '0)
                  mode <= PMC_ACTIVE;
               else
                  wake_cnt <= wake_cnt - 32'h0000_0001;
            default: mode <= PMC_ACTIVE;
         endcase
      end
   end

   // wake pending flag and gpio edge history
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wake_pend <= 1'b0;
         gpio_d    <= '0;
      end
      else
      begin
         gpio_d    <= gpio_s;
         wake_pend <= (mode == PMC_WAKING);
      end
   end

   // fast timer counts down only in sleep
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ftimer <= '0;
      else if (mode != PMC_SLEEP)
         ftimer <= ftimer_load;
      else if (ftimer > 16'h0001)
         ftimer <= ftimer - 16'h0001;
   end

   // ========================================================================
   // power and clock outputs; ordering keeps power falling with mode depth
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cpu_clk_en     <= 1'b1;
         cpu_clk_mult   <= 3'(PLL_MULT);
         cpu_state_keep <= 1'b1;
         cfg_keep_en    <= 1'b1;
         mem_bank_on    <= '1;
         logic_power_on <= 1'b1;
         rtc_power_on   <= 1'b1;
         app_reload     <= 1'b0;
      end
      else
      begin
         cpu_clk_mult   <= 3'(PLL_MULT);
         cpu_clk_en     <= (mode == PMC_ACTIVE);
         cpu_state_keep <= (mode == PMC_ACTIVE) || (mode == PMC_SLEEP);
         cfg_keep_en    <= (mode <= PMC_DEEP) || (mode == PMC_WAKING);
         mem_bank_on    <= (mode <= PMC_SLEEP || mode == PMC_WAKING && target == PMC_DEEP)
                         ? '1 : (mode == PMC_DEEP ? retain : '0);
         logic_power_on <= (mode <= PMC_DEEP) || (mode == PMC_WAKING);
         rtc_power_on   <= (mode != PMC_SHUTDOWN);
         app_reload     <= (mode == PMC_WAKING) && (target != PMC_DEEP);
      end
   end

   // ========================================================================
   // network cycle, independent of the processor mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         net     <= PMC_NET_OFF;
         net_cnt <= '0;
      end
      else
      begin
         case (net)
            PMC_NET_OFF:
               if (net_en)
                  net <= PMC_NET_ACTIVE;
            PMC_NET_ACTIVE:
               if (!net_en)
                  net <= PMC_NET_OFF;
               else if (!net_traffic)
               begin
                  net     <= PMC_NET_DEEP;
                  net_cnt <= long_en ? 35'(LONG_SLEEP - 1) : 35'(BEACON_PERIOD - 1);
               end
            PMC_NET_DEEP:
               if (!net_en)
                  net <= PMC_NET_OFF;
               else if (net_cnt == '0)
               begin
                  net     <= PMC_NET_LISTEN;
                  net_cnt <= 35'(LISTEN_WIN - 1);
               end
               else
                  net_cnt <= net_cnt - 35'h1;
            PMC_NET_LISTEN:
               if (frame_valid && frame_is_beacon && beacon_pending)
                  net <= PMC_NET_ACTIVE;
               else if ((frame_valid && frame_is_beacon) || net_cnt == '0)
               begin
                  net     <= PMC_NET_DEEP;
                  net_cnt <= long_en ? 35'(LONG_SLEEP - 1) : 35'(BEACON_PERIOD - 1);
               end
               else
                  net_cnt <= net_cnt - 35'h1;
            default: net <= PMC_NET_OFF;
         endcase
      end
   end

   // frame filter and retention flag
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         frame_accept   <= 1'b0;
         net_state_keep <= 1'b0;
      end
      else
      begin
         frame_accept   <= frame_valid && (net == PMC_NET_ACTIVE
                        || (net == PMC_NET_LISTEN && frame_is_beacon));
         net_state_keep <= (net == PMC_NET_DEEP) || (net == PMC_NET_LISTEN);
      end
   end

   // ========================================================================
   // apb configuration registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wake_cfg    <= '0;
         gpio_sel    <= '0;
         retain      <= '0;
         ftimer_load <= 16'hFFFF;
         long_en     <= 1'b0;
         net_en      <= 1'b0;
         irq_mask    <= '0;
         cfg_keep    <= RESET_WORD;
      end
      else if (wr_req)
      begin
         case (paddr)
            REG_WAKE_CFG:
            begin
               wake_cfg <= pwdata[3:0];
               gpio_sel <= pwdata[WK_GPIO_SEL +: GPIO_W];
            end
            REG_RETAIN:   retain      <= pwdata[BANKS-1:0];
            REG_FTIMER:   ftimer_load <= pwdata[15:0];
            REG_NET_CFG:
            begin
               net_en  <= pwdata[0];
               long_en <= pwdata[1];
            end
            REG_IRQ_MASK: irq_mask    <= pwdata[IRQ_W-1:0];
            REG_CFG_KEEP: if (mode == PMC_ACTIVE) cfg_keep <= pwdata;
            default: ;
         endcase
      end
   end

   // sticky status; a new event wins over the read clear, and only the bits
   // the reader was shown are cleared, so an event at the setup edge survives
   logic [IRQ_W-1:0] evt;
   assign evt = {(net == PMC_NET_LISTEN && frame_valid && frame_is_beacon && beacon_pending),
                 (mode_wr && !req_ok), wake_hit};
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_stat <= '0;
      else if (rd_req && paddr == REG_IRQ_STAT)
         irq_stat <= (irq_stat & ~prdata[IRQ_W-1:0]) | evt;
      else
         irq_stat <= irq_stat | evt;
   end

   // read mux and answer; zero wait states
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         irq     <= 1'b0;
      end
      else
      begin
         irq     <= |(irq_stat & irq_mask);
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= '0;
         if (psel && !penable)
         begin
            case (paddr)
               REG_MODE_REQ:  prdata <= {29'h0, target};
               REG_MODE_STAT: prdata <= {27'h0, net, mode};
               REG_WAKE_CFG:  prdata <= {16'h0, 8'(gpio_sel), 4'h0, wake_cfg};
               REG_RETAIN:    prdata <= 32'(retain);
               REG_FTIMER:    prdata <= {16'h0, ftimer_load};
               REG_NET_CFG:   prdata <= {30'h0, long_en, net_en};
               REG_IRQ_STAT:  prdata <= 32'(irq_stat);
               REG_IRQ_MASK:  prdata <= 32'(irq_mask);
               REG_CFG_KEEP:  prdata <= cfg_keep;
               default:       pslverr <= 1'b1;
            endcase
         end
      end
   end

   // ========================================================================
   // checks
   sleep_clk_a: assert property (@(posedge pclk) disable iff (!presetn)
      mode == PMC_SLEEP |=> !cpu_clk_en) else $error("clock runs in sleep");
   sleep_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
      mode == PMC_SLEEP && wake_hit && shut_n_s |=> mode == PMC_ACTIVE)
      else $error("sleep wake missed");
   ds_state_a: assert property (@(posedge pclk) disable iff (!presetn)
      mode == PMC_DEEP |=> !cpu_state_keep && cfg_keep_en)
      else $error("deep sleep retention wrong");
   ds_retain_a: assert property (@(posedge pclk) disable iff (!presetn)
      mode == PMC_DEEP && $stable(mode) |=> mem_bank_on == $past(retain))
      else $error("bank retention wrong");
   hib_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      mode == PMC_HIBERNATE |=> !logic_power_on && rtc_power_on)
      else $error("hibernate gating wrong");
   shut_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      !shut_n_s |=> mode == PMC_SHUTDOWN ##1 !rtc_power_on)
      else $error("shutdown not entered");
   listen_filt_a: assert property (@(posedge pclk) disable iff (!presetn)
      net == PMC_NET_LISTEN && frame_valid && !frame_is_beacon |=> !frame_accept)
      else $error("non beacon accepted");
   req_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
      mode == PMC_WAKING && mode_wr && shut_n_s && wake_cnt != '0 |=> mode == PMC_WAKING)
      else $error("request taken while waking");
   net_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      net == PMC_NET_DEEP |=> net_state_keep) else $error("net state dropped");
endmodule // pmc_top

// [verification/tb_power_mode_controller.sv]
// self-checking bench for the power mode controller
`timescale 1ns/1ps
module tb_power_mode_controller;
   import pmc_pkg::*;
   // ======================================================================
   // signals and counters
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr, gpio_in;
   logic [31:0] pwdata, prdata, rd;
   logic        shut_n, periph_activity, rtc_expired, net_traffic;
   logic        frame_valid, frame_is_beacon, beacon_pending, frame_accept;
   logic        cpu_clk_en, cpu_state_keep, cfg_keep_en, logic_power_on;
   logic        rtc_power_on, app_reload, net_state_keep, irq;
   logic [2:0]  cpu_clk_mult;
   logic [3:0]  mem_bank_on;
   int          fail_count = 0;
   int          comparisons = 0;
   int          n;
   // shortened wake counts keep the run to a few hundred cycles; widths and
   // the long interval keep their defaults
   pmc_top #(.DS_WAKE(20), .HIB_WAKE(30), .SHUT_WAKE(10),
      .BEACON_PERIOD(16), .LISTEN_WIN(8)) uut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .shutdown_control_line_n(shut_n), .gpio_in(gpio_in),
      .periph_activity(periph_activity), .rtc_expired(rtc_expired),
      .net_traffic(net_traffic), .frame_valid(frame_valid),
      .frame_is_beacon(frame_is_beacon), .beacon_pending(beacon_pending),
      .cpu_clk_en(cpu_clk_en), .cpu_clk_mult(cpu_clk_mult),
      .cpu_state_keep(cpu_state_keep), .cfg_keep_en(cfg_keep_en),
      .mem_bank_on(mem_bank_on), .logic_power_on(logic_power_on),
      .rtc_power_on(rtc_power_on), .app_reload(app_reload),
      .net_state_keep(net_state_keep), .frame_accept(frame_accept), .irq(irq));
   // ======================================================================
   // clock, 50 ns period
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // ======================================================================
   // helpers
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the answer
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // bounded wait for the processor clock to return; n counts cycles
   task automatic wait_on(input int lim);
      n = 0;
      while (cpu_clk_en !== 1'b1 && n < lim)
      begin
         @(negedge pclk);
         n++;
      end
   endtask
   // bounded poll of the network state field until it reaches the wanted code
   task automatic wait_net(input logic [1:0] st);
      for (int i = 0; i < 40; i++)
      begin
         apb(1'b0, REG_MODE_STAT, 32'h0);
         if (rd[4:3] === st)
            break;
      end
      chk(rd[4:0], {st, 3'h0});
   endtask
   task automatic frame(input logic bcn, input logic pend, input logic exp);
      @(posedge pclk);
      frame_valid <= 1'b1;
      frame_is_beacon <= bcn;
      beacon_pending <= pend;
      @(posedge pclk);
      frame_valid <= 1'b0;
      @(negedge pclk);
      chk(frame_accept, exp);
   endtask
   // ======================================================================
   // scenarios
   task automatic t_sleep;
      apb(1'b1, REG_WAKE_CFG, 32'h0000_FF0E);
      apb(1'b1, REG_MODE_REQ, 32'h1);
      repeat (2) @(negedge pclk);
      chk({cpu_clk_en, cpu_state_keep, mem_bank_on}, 6'h1F);
      @(posedge pclk);
      periph_activity <= 1'b1;
      wait_on(20);
      chk(32'(n <= 5), 1);
      @(posedge pclk);
      periph_activity <= 1'b0;
   endtask
   task automatic t_deep;
      apb(1'b1, REG_CFG_KEEP, 32'h0000_00A5);
      apb(1'b1, REG_RETAIN, 32'h5);
      apb(1'b1, REG_MODE_REQ, 32'h2);
      repeat (2) @(negedge pclk);
      chk({cpu_clk_en, cpu_state_keep, cfg_keep_en}, 3'b001);
      chk(mem_bank_on, 4'h5);
      @(posedge pclk);
      rtc_expired <= 1'b1;
      wait_on(60);
      chk(32'(n >= 20 && n <= 26), 1);
      @(posedge pclk);
      rtc_expired <= 1'b0;
      apb(1'b0, REG_CFG_KEEP, 32'h0);
      chk(rd, 32'h0000_00A5);
   endtask
   task automatic t_hib;
      apb(1'b1, REG_MODE_REQ, 32'h3);
      repeat (2) @(negedge pclk);
      chk({logic_power_on, rtc_power_on, mem_bank_on}, 6'h10);
      @(posedge pclk);
      gpio_in <= 8'h01;
      repeat (6) @(negedge pclk);
      chk(app_reload, 1'b1);
      wait_on(60);
      chk(32'(n >= 24 && n <= 34), 1);
      @(posedge pclk);
      gpio_in <= 8'h00;
   endtask
   task automatic t_reject;
      apb(1'b1, REG_IRQ_MASK, 32'h7);
      apb(1'b0, REG_IRQ_STAT, 32'h0);
      apb(1'b1, REG_MODE_REQ, 32'h4);
      repeat (2) @(negedge pclk);
      chk({irq, cpu_clk_en}, 2'b11);
      apb(1'b0, REG_IRQ_STAT, 32'h0);
      chk(rd[IRQ_REJECT], 1'b1);
      apb(1'b0, REG_IRQ_STAT, 32'h0);
      chk({irq, rd}, 33'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk({err, rd}, 33'h1_0000_0000);
   endtask
   task automatic t_shut;
      @(posedge pclk);
      shut_n <= 1'b0;
      repeat (5) @(negedge pclk);
      chk({rtc_power_on, logic_power_on, cpu_clk_en}, 3'b000);
      @(posedge pclk);
      shut_n <= 1'b1;
      wait_on(40);
      chk(32'(n >= 10 && n <= 16), 1);
   endtask
   task automatic t_net;
      apb(1'b1, REG_NET_CFG, 32'h1);
      wait_net(2'h1);
      chk(net_state_keep, 1'b1);
      frame(1'b0, 1'b0, 1'b0);
      wait_net(2'h2);
      chk({net_state_keep, cpu_clk_en}, 2'b11);
      wait_net(2'h1);
      net_traffic <= 1'b1;
      frame(1'b1, 1'b1, 1'b1);
      wait_net(2'h0);
      apb(1'b1, REG_NET_CFG, 32'h0);
   endtask
   // ======================================================================
   // verdict, reached from the main sequence or the watchdog
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // main sequence: reset values first, then each mode in turn
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, gpio_in} = '0;
      {periph_activity, rtc_expired, net_traffic} = '0;
      {frame_valid, frame_is_beacon, beacon_pending} = '0;
      shut_n = 1'b1;
      repeat (10) @(posedge pclk);
      chk(cpu_clk_mult, 3'(PLL_MULT));
      chk({cpu_clk_en, mem_bank_on, rtc_power_on, irq}, 7'h7E);
      presetn <= 1'b1;
      repeat (4) @(negedge pclk);
      wait_on(40);
      chk(cpu_clk_mult, 3'(PLL_MULT));
      t_sleep();
      t_deep();
      t_hib();
      t_reject();
      t_shut();
      t_net();
      end_of_test();
   end
   // watchdog well beyond the few hundred cycles the scenarios need
   initial
   begin
      #2_000_000;
      fail_count++;
      $display("ERROR at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule // tb_power_mode_controller
